// file: rtl/ddcd_top.sv
// How it works
// - Execute command on 24th falling clock edge
// - Early frame-select rise aborts, clears shifter
// - Aborted frame changes no buffer or mode
// - Store data per select; load A option
// - Load B from buffer B after write
// - Both loads update on same edge
// - Nonzero power field stores power command
// - Load A applies buffer A contents only
// - Mode changes only on load of buffer
// - Separate power modes for both channels
// - Code 00 means normal amplifier output
// - Codes select 1k, 100k or open
// - Power-down switches pin to termination
// - Power-down asserts channel analogue shutdown
// - Exit only by normal write plus load
// - Output valid after wake-up interval
// - Sample data on each falling clock edge
// - Bit 19 is ignored entirely
// - Reset clears both converter registers
`timescale 1ns/1ps
`default_nettype none
module ddcd_top (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic frame_sel_n,
  input wire logic din,
  output var ddcd_pkg::ddcd_chan_t chan_a,
  output var ddcd_pkg::ddcd_chan_t chan_b,
  output logic cmd_done
);

  ddcd_pkg::ddcd_state_reg_t s_r;
  ddcd_pkg::ddcd_state_reg_t s_nxt;

  logic sclk_fall;
  logic sync_fall;
  logic sync_hi;
  logic [23:0] frame;
  ddcd_pkg::ddcd_buf_t wr;
  ddcd_pkg::ddcd_buf_t nb_a;
  ddcd_pkg::ddcd_buf_t nb_b;
  logic update_first_chan;
  logic update_second_chan;
  logic power_mode_hi;
  logic power_mode_lo;
  logic buf_sel_b;

  // Stage 0 is read only by stage 1; edges use stages 1 and 2
  assign sclk_fall = s_r.sclk_s[2] & ~s_r.sclk_s[1];
  assign sync_fall = s_r.sync_s[2] & ~s_r.sync_s[1];
  assign sync_hi = s_r.sync_s[1];
  // Din is delayed like sclk so it lines up with the edge
  assign frame = {s_r.shreg[22:0], s_r.din_s[1]};
  // Command fields as they stand once the last bit is in
  assign update_first_chan = frame[ddcd_pkg::POS_LOAD_A];
  assign update_second_chan = frame[ddcd_pkg::POS_LOAD_B];
  assign power_mode_hi = frame[ddcd_pkg::POS_PD_HI];
  assign power_mode_lo = frame[ddcd_pkg::POS_PD_LO];
  assign buf_sel_b = frame[ddcd_pkg::POS_BUF_SEL];

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.sclk_s = {s_r.sclk_s[1:0], sclk};
    s_nxt.sync_s = {s_r.sync_s[1:0], frame_sel_n};
    s_nxt.din_s = {s_r.din_s[0], din};
    s_nxt.exec = 1'b0;
    wr.data = frame[15:0];
    wr.pd = {power_mode_hi, power_mode_lo};
    // Data bits ignored under a power command; bit 19 never read
    if (wr.pd != ddcd_pkg::PM_NORMAL)
    begin
      wr.data = s_r.buf_a.data;
      if (buf_sel_b)
        wr.data = s_r.buf_b.data;
    end
    nb_a = s_r.buf_a;
    nb_b = s_r.buf_b;
    if (buf_sel_b)
      nb_b = wr;
    else
      nb_a = wr;

    // Count down first so a fresh wake-up load below wins
    if (s_r.wake_a != '0)
      s_nxt.wake_a = s_r.wake_a - 7'h01;
    if (s_r.wake_b != '0)
      s_nxt.wake_b = s_r.wake_b - 7'h01;

    case (s_r.st)
      ddcd_pkg::ST_IDLE:
      begin
        if (sync_fall)
        begin
          s_nxt.cnt = '0;
          s_nxt.shreg = '0;
          s_nxt.st = ddcd_pkg::ST_SHIFT;
        end
      end
      ddcd_pkg::ST_SHIFT:
      begin
        // The 24th edge may meet the select rise in one sample; it
        // still counts, since the rise is legal from that edge on
        if (sclk_fall && (!sync_hi || s_r.cnt == ddcd_pkg::LAST_BIT))
        begin
          s_nxt.shreg = frame;
          s_nxt.cnt = s_r.cnt + 5'h01;
          if (s_r.cnt == ddcd_pkg::LAST_BIT)
          begin
            s_nxt.exec = 1'b1;
            s_nxt.buf_a = nb_a;
            s_nxt.buf_b = nb_b;
            // Both loads see the freshly written buffers at once
            if (update_first_chan)
            begin
              s_nxt.mode_a = nb_a.pd;
              if (nb_a.pd == ddcd_pkg::PM_NORMAL)
              begin
                s_nxt.dac_a = nb_a.data;
                if (s_r.mode_a != ddcd_pkg::PM_NORMAL)
                  s_nxt.wake_a = 7'(ddcd_pkg::WAKE_CYC);
              end
            end
            if (update_second_chan)
            begin
              s_nxt.mode_b = nb_b.pd;
              if (nb_b.pd == ddcd_pkg::PM_NORMAL)
              begin
                s_nxt.dac_b = nb_b.data;
                if (s_r.mode_b != ddcd_pkg::PM_NORMAL)
                  s_nxt.wake_b = 7'(ddcd_pkg::WAKE_CYC);
              end
            end
            s_nxt.st = ddcd_pkg::ST_DONE;
          end
        end
        else if (sync_hi)
        begin
          s_nxt.shreg = '0;
          s_nxt.cnt = '0;
          s_nxt.st = ddcd_pkg::ST_IDLE;
        end
      end
      ddcd_pkg::ST_DONE:
      begin
        // Extra clocks after the 24th are ignored until a new frame
        s_nxt.shreg = '0;
        if (sync_hi)
          s_nxt.st = ddcd_pkg::ST_IDLE;
      end
      default: s_nxt.st = ddcd_pkg::ST_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_r <= '0;
      // Idle level of the parked link clock, so no edge follows reset
      s_r.sclk_s <= 3'h7;
      s_r.sync_s <= 3'h7;
      s_r.st <= ddcd_pkg::ST_IDLE;
      s_r.dac_a <= ddcd_pkg::DAC_RST;
      s_r.dac_b <= ddcd_pkg::DAC_RST;
      s_r.mode_a <= ddcd_pkg::PM_NORMAL;
      s_r.mode_b <= ddcd_pkg::PM_NORMAL;
    end
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  ddcd_chan_drv #(
    .WAKE_BITS(ddcd_pkg::WAKE_W)
  ) drv_a (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .code_nxt(s_nxt.dac_a),
    .mode_nxt(s_nxt.mode_a),
    .wake_nxt(s_nxt.wake_a),
    .chan(chan_a)
  );

  ddcd_chan_drv #(
    .WAKE_BITS(ddcd_pkg::WAKE_W)
  ) drv_b (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .code_nxt(s_nxt.dac_b),
    .mode_nxt(s_nxt.mode_b),
    .wake_nxt(s_nxt.wake_b),
    .chan(chan_b)
  );

  assign cmd_done = s_r.exec;

endmodule

////////////////////////////////////////////////////////////////////////
// One channel's analogue controls, registered so every output is a flop
module ddcd_chan_drv #(
  parameter int WAKE_BITS = ddcd_pkg::WAKE_W
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [15:0] code_nxt,
  input wire logic [1:0] mode_nxt,
  input wire logic [WAKE_BITS-1:0] wake_nxt,
  output var ddcd_pkg::ddcd_chan_t chan
);

  ddcd_pkg::ddcd_chan_t c_r;
  ddcd_pkg::ddcd_chan_t c_nxt;

  // Decoded from next-state values so all fields move on one edge
  always_comb
  begin
    c_nxt.code = code_nxt;
    c_nxt.mode = mode_nxt;
    c_nxt.sel_amp = (mode_nxt == ddcd_pkg::PM_NORMAL);
    c_nxt.shutdown = (mode_nxt != ddcd_pkg::PM_NORMAL);
    c_nxt.sel_1k = (mode_nxt == ddcd_pkg::PM_1K);
    c_nxt.sel_100k = (mode_nxt == ddcd_pkg::PM_100K);
    // Held low while the amplifier is still waking up
    c_nxt.valid = c_nxt.sel_amp && (wake_nxt == '0);
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      c_r <= '0;
      c_r.code <= ddcd_pkg::DAC_RST;
      c_r.mode <= ddcd_pkg::PM_NORMAL;
      c_r.sel_amp <= 1'b1;
      c_r.valid <= 1'b1;
    end
    else
      c_r <= c_nxt;
  end

  assign chan = c_r;

endmodule
`default_nettype wire

// file: inc/ddcd_pkg.sv
`default_nettype none
package ddcd_pkg;
  localparam int FRAME_BITS = 24;
  localparam int CNT_W = 5;
  localparam logic [4:0] LAST_BIT = 5'h17;
  localparam int POS_LOAD_B = 21;
  localparam int POS_LOAD_A = 20;
  localparam int POS_BUF_SEL = 18;
  localparam int POS_PD_HI = 17;
  localparam int POS_PD_LO = 16;
  localparam logic [1:0] PM_NORMAL = 2'h0;
  localparam logic [1:0] PM_1K = 2'h1;
  localparam logic [1:0] PM_100K = 2'h2;
  localparam logic [1:0] PM_HIZ = 2'h3;
  localparam logic [15:0] DAC_RST = 16'h0000;
  localparam int CLK_MHZ = 25;
  localparam int WAKE_NS = 2500;
  localparam int WAKE_CYC = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_W = 7;

  // One data buffer entry: either data or a power-down command
  typedef struct packed {
    logic [15:0] data;
    logic [1:0] pd;
  } ddcd_buf_t;

  // Per-channel analogue control
  typedef struct packed {
    logic [15:0] code;
    logic [1:0] mode;
    logic shutdown;
    logic sel_amp;
    logic sel_1k;
    logic sel_100k;
    logic valid;
  } ddcd_chan_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SHIFT = 3'h2,
    ST_DONE = 3'h4
  } ddcd_state_t;

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [2:0] sync_s;
    logic [1:0] din_s;
    ddcd_state_t st;
    logic [23:0] shreg;
    logic [4:0] cnt;
    ddcd_buf_t buf_a;
    ddcd_buf_t buf_b;
    logic [15:0] dac_a;
    logic [15:0] dac_b;
    logic [1:0] mode_a;
    logic [1:0] mode_b;
    logic [6:0] wake_a;
    logic [6:0] wake_b;
    logic exec;
  } ddcd_state_reg_t;
endpackage
`default_nettype wire

// file: testbench/ddcd_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ddcd_chk (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic frame_sel_n,
  input wire ddcd_pkg::ddcd_chan_t chan_a,
  input wire ddcd_pkg::ddcd_chan_t chan_b,
  input wire logic cmd_done
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  a_done_pulse: assert property (cmd_done |=> !cmd_done)
    else $error("done too long");
  a_abort_quiet: assert property (frame_sel_n [*8] |-> !cmd_done)
    else $error("done without frame");
  a_code_hold: assert property
    ($changed({chan_a.code, chan_b.code}) |-> cmd_done)
    else $error("code moved idle");
  a_mode_hold: assert property
    ($changed({chan_a.mode, chan_b.mode}) |-> cmd_done)
    else $error("mode moved idle");
  a_amp_route: assert property
    (chan_a.sel_amp == (chan_a.mode == ddcd_pkg::PM_NORMAL) &&
     chan_b.sel_amp == (chan_b.mode == ddcd_pkg::PM_NORMAL))
    else $error("amp select");
  a_shut_mode: assert property
    (chan_a.shutdown == (chan_a.mode != ddcd_pkg::PM_NORMAL) &&
     chan_b.shutdown == (chan_b.mode != ddcd_pkg::PM_NORMAL))
    else $error("shutdown");
  a_term_sel: assert property
    (chan_a.sel_1k == (chan_a.mode == ddcd_pkg::PM_1K) &&
     chan_a.sel_100k == (chan_a.mode == ddcd_pkg::PM_100K) &&
     chan_b.sel_1k == (chan_b.mode == ddcd_pkg::PM_1K) &&
     chan_b.sel_100k == (chan_b.mode == ddcd_pkg::PM_100K))
    else $error("termination");
  a_wake_gap_b: assert property
    ($changed(chan_b.mode) && chan_b.mode == ddcd_pkg::PM_NORMAL
     |-> ##1 !chan_b.valid [*8])
    else $error("valid early b");
  a_wake_end: assert property
    ($changed(chan_a.mode) && chan_a.mode == ddcd_pkg::PM_NORMAL
     |-> ##62 !chan_a.valid ##1 chan_a.valid)
    else $error("valid late");
  a_wake_gap: assert property
    ($changed(chan_a.mode) && chan_a.mode == ddcd_pkg::PM_NORMAL
     |-> ##1 !chan_a.valid [*8])
    else $error("valid early");
  a_reset_zero: assert property
    ($rose(nrst) |-> chan_a.code == 16'h0000 && chan_b.code == 16'h0000)
    else $error("reset code");
endmodule
bind ddcd_top ddcd_chk chk (
  .sys_clk(sys_clk),
  .nrst(nrst),
  .frame_sel_n(frame_sel_n),
  .chan_a(chan_a),
  .chan_b(chan_b),
  .cmd_done(cmd_done)
);
`default_nettype wire

// file: testbench/ddcd_host.sv
`timescale 1ns/1ps
`default_nettype none
module ddcd_host (
  output var logic sclk,
  output var logic frame_sel_n,
  output var logic din
);
  initial
  begin
    sclk = 1'b1;
    frame_sel_n = 1'b1;
    din = 1'b0;
  end
  // Clock parked high outside frames
  task automatic send(input logic [23:0] w, input int n);
    frame_sel_n = 1'b0;
    for (int i = 23; i > 23 - n; i--)
    begin
      din = w[i];
      #160 sclk = 1'b0;
      #160 sclk = 1'b1;
    end
    #80 frame_sel_n = 1'b1;
    din = ~din;
    #200;
  endtask
endmodule
`default_nettype wire

// file: testbench/tb_dual_dac_command_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dual_dac_command_decoder;
  logic sys_clk;
  logic nrst;
  wire sclk;
  wire frame_sel_n;
  wire din;
  ddcd_pkg::ddcd_chan_t chan_a;
  ddcd_pkg::ddcd_chan_t chan_b;
  logic cmd_done;
  int err_count = 0;
  int checks = 0;
  int dones = 0;
  // Each row: command word, then codes a, b and modes a, b after it
  logic [59:0] rows [8] = '{
    {24'h001234, 36'h000000000},
    {24'h345678, 36'h123456780},
    {24'h18ABCD, 36'hABCD56780},
    {24'h010000, 36'hABCD56780},
    {24'h360000, 36'hABCD56786},
    {24'h270000, 36'hABCD56787},
    {24'h100001, 36'h000156783},
    {24'h150000, 36'h000156783}
  };
  ddcd_host host (.sclk(sclk), .frame_sel_n(frame_sel_n), .din(din));
  ddcd_top dut (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .sclk(sclk),
    .frame_sel_n(frame_sel_n),
    .din(din),
    .chan_a(chan_a),
    .chan_b(chan_b),
    .cmd_done(cmd_done)
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
    if (cmd_done === 1'b1)
      dones <= dones + 1;
  task automatic check(input string nm, input logic [35:0] s,
    input logic [35:0] e);
    checks++;
    if (s !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic summarize;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic frame(input logic [23:0] w, input int n,
    input logic [35:0] e);
    int d0;
    @(posedge sys_clk);
    #2 d0 = dones;
    host.send(w, n);
    repeat (8) @(posedge sys_clk);
    #2 check("done", 36'(dones - d0), 36'(n == 24));
    check("chan",
      {chan_a.code, chan_b.code, chan_a.mode, chan_b.mode}, e);
  endtask
  task automatic pulse_reset;
    #2 nrst = 1'b0;
    repeat (2) @(posedge sys_clk);
    #2 nrst = 1'b1;
    repeat (3) @(posedge sys_clk);
    #2 check("rst",
      {chan_a.code, chan_b.code, chan_a.mode, chan_b.mode}, 36'h0);
  endtask
  initial
  begin
    nrst = 1'b0;
    @(posedge sys_clk);
    pulse_reset();
    for (int i = 0; i < 8; i++)
      frame(rows[i][59:36], 24,
        rows[i][35:0]);
    frame(24'h2C9999, 10, 36'h000156783);
    frame(24'h240042, 24, 36'h000100420);
    check("wake", 36'(chan_b.valid), 36'h0);
    repeat (ddcd_pkg::WAKE_CYC) @(posedge sys_clk);
    #2 check("woke", 36'(chan_b.valid), 36'h1);
    @(posedge sys_clk);
    pulse_reset();
    summarize();
  end
  initial
  begin
    #200000;
    err_count++;
    summarize();
  end
endmodule
`default_nettype wire
